// File: design/tce_pkg.sv
package tce_pkg;

   // register offsets on the plain port
   localparam logic [7:0] REG_CONFIG   = 8'h00;
   localparam logic [7:0] REG_CHAN_CTL = 8'h01;
   localparam logic [7:0] REG_STATE    = 8'h02;
   localparam logic [7:0] REG_CHANGE   = 8'h03;
   localparam logic [7:0] REG_IRQ_CFG  = 8'h04;

   // field positions
   localparam int CFG_SSD_BIT  = 7;
   localparam int CFG_SS_LSB   = 5;
   localparam int IRQ_ACI_LSB  = 6;

   // values after reset
   localparam logic [7:0] RST_CONFIG   = 8'h00;
   localparam logic [7:0] RST_CHAN_CTL = 8'hFF;
   localparam logic [1:0] RST_ACI      = 2'h0;

   // slave address fixed upper bits
   localparam logic [4:0] SLAVE_ADDR_HI = 5'h11;

   // auto-clear selector codes
   localparam logic [1:0] ACI_NONE  = 2'h0;
   localparam logic [1:0] ACI_SHORT = 2'h1;
   localparam logic [1:0] ACI_LONG  = 2'h2;

   // sensitivity codes and detection thresholds
   localparam logic [1:0] SS_NORMAL = 2'h0;
   localparam logic [1:0] SS_HIGH   = 2'h1;
   localparam logic [1:0] SS_LOW    = 2'h2;
   localparam logic [3:0] TH_ON_NORM = 4'hC;
   localparam logic [3:0] TH_ON_HIGH = 4'h8;
   localparam logic [3:0] TH_ON_LOW  = 4'hE;
   localparam logic [3:0] TH_OFF     = 4'h4;
   localparam logic [3:0] CNT_MAX    = 4'hF;

   // timing
   localparam int CLK_MHZ           = 250;
   localparam int AUTOCLR_SHORT_MS  = 8;
   localparam int AUTOCLR_LONG_MS   = 32;
   localparam int unsigned RECAL_MS = 10000;
   localparam int AUTOCLR_SHORT_CYC = AUTOCLR_SHORT_MS * 1000 * CLK_MHZ;
   localparam int AUTOCLR_LONG_CYC  = AUTOCLR_LONG_MS * 1000 * CLK_MHZ;
   localparam int unsigned RECAL_CYC = RECAL_MS * 1000 * CLK_MHZ;  // beyond the signed 32-bit range

endpackage

// File: design/tce_touch_event.sv
// Function
// - pressed channel pulls its open-drain output low
// - touch or release event asserts active-low interrupt
// - interrupt clear behaviour selected by software register
// - shutdown input low suspends sensing and outputs
// - disabled channels give no output or event
// - baseline tracking absorbs drift, adapts thresholds (here thresholds stay fixed by the sensitivity code)
// - slave address partly set by strap input
// - address is 10001 then two strap bits
// - accessing change register deasserts the interrupt
// - auto-clear field: none, 8ms, 32ms, invalid
// - channel enables in D3:D0, reset all ones
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tce_touch_event
   import tce_pkg::*;
#(
   parameter int unsigned P_AUTOCLR_SHORT_CYC = AUTOCLR_SHORT_CYC,
   parameter int unsigned P_AUTOCLR_LONG_CYC  = AUTOCLR_LONG_CYC,
   parameter int unsigned P_RECAL_CYC         = RECAL_CYC
) (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_reset,
   // pins
   input  wire logic [3:0] i_sense_in,
   input  wire logic       i_shutdown_n,
   input  wire logic [1:0] i_addr_strap,
   input  wire logic [2:0] i_touch_out_low_ch,
   output logic      [2:0] o_touch_out_low_ch,
   output logic      [2:0] o_touch_out_low_ch_oe,
   input  wire logic       i_touch_out_low_last_ch,
   output logic            o_touch_out_low_last_ch,
   output logic            o_touch_out_low_last_ch_oe,
   output logic            o_irq_n,
   output logic      [6:0] o_slave_addr,
   // register port
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wr_data,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rd_data
);

   // pin synchronisers: sense, shutdown, strap; they run through reset so the strap
   // is already settled at the first edge after release, when the address is captured
   logic [6:0] sync1_q, sync2_q;
   always_ff @(posedge i_clk) begin
      sync1_q <= {i_addr_strap, i_shutdown_n, i_sense_in};
      sync2_q <= sync1_q;
   end

   logic [3:0] sense_s;
   logic       run;
   logic [3:0] en;
   logic [3:0] thr_on;
   logic [7:0] config_q, config_d, chan_ctl_q, chan_ctl_d;
   logic [1:0] aci_q, aci_d;
   logic [3:0] pressed_q, pressed_d, change_q, change_d, ev;
   logic       irq_q, irq_d;
   logic       irq_n_q, irq_n_d;
   logic [31:0] tmr_q, tmr_d;
   logic [7:0] rd_q, rd_d;
   logic [3:0] oe_q, oe_d;
   logic [6:0] saddr_q, saddr_d;
   logic       cap_q, cap_d;
   logic       chg_access;

   assign sense_s = sync2_q[3:0];
   assign run     = sync2_q[4] && !config_q[CFG_SSD_BIT];
   assign en      = chan_ctl_q[3:0];
   assign chg_access = (i_rd || i_wr) && (i_addr == REG_CHANGE);

   // on threshold follows sensitivity selection
   always_comb begin
      case (config_q[CFG_SS_LSB +: 2])
         SS_HIGH: thr_on = TH_ON_HIGH;
         SS_LOW:  thr_on = TH_ON_LOW;
         default: thr_on = TH_ON_NORM;
      endcase
   end

   // per-channel detector with baseline tracking
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_chan
         logic [3:0]  cnt_q, cnt_d;
         logic [31:0] hold_q, hold_d;
         logic        base_q, base_d;
         logic        prs;
         always_comb begin
            cnt_d  = cnt_q;
            hold_d = hold_q;
            base_d = base_q;
            prs    = pressed_q[g];
            if (!run || !en[g]) begin
               cnt_d  = 4'h0;
               hold_d = 32'h0;
               base_d = 1'b0;
               prs    = 1'b0;
            end else begin
               if (base_q) begin
                  cnt_d = 4'h0;
                  if (!sense_s[g]) base_d = 1'b0;
               end else if (sense_s[g] && cnt_q != CNT_MAX) begin
                  cnt_d = cnt_q + 4'h1;
               end else if (!sense_s[g] && cnt_q != 4'h0) begin
                  cnt_d = cnt_q - 4'h1;
               end
               if (cnt_q >= thr_on) prs = 1'b1;
               else if (cnt_q <= TH_OFF) prs = 1'b0;
               hold_d = prs ? hold_q + 32'h1 : 32'h0;
               if (prs && hold_q >= P_RECAL_CYC - 1) begin
                  prs    = 1'b0;
                  base_d = 1'b1;
                  hold_d = 32'h0;
                  cnt_d  = 4'h0;
               end
            end
            pressed_d[g] = prs;
            ev[g] = run && en[g] && (prs != pressed_q[g]);
            change_d[g] = ev[g] | (change_q[g] && !(i_rd && i_addr == REG_CHANGE));
            oe_d[g] = prs;
         end
         always_ff @(posedge i_clk or posedge i_reset) begin
            if (i_reset) begin
               cnt_q  <= 4'h0;
               hold_q <= 32'h0;
               base_q <= 1'b0;
            end else begin
               cnt_q  <= cnt_d;
               hold_q <= hold_d;
               base_q <= base_d;
            end
         end
      end
   endgenerate

   // registers, interrupt, read data, address capture
   always_comb begin
      config_d   = config_q;
      chan_ctl_d = chan_ctl_q;
      aci_d      = aci_q;
      irq_d      = irq_q;
      tmr_d      = tmr_q;
      rd_d       = 8'h00;
      saddr_d    = saddr_q;
      cap_d      = 1'b1;
      if (!cap_q) saddr_d = {SLAVE_ADDR_HI, sync2_q[6:5]};
      if (i_wr) begin
         case (i_addr)
            REG_CONFIG:   config_d   = i_wr_data & 8'hE0;
            REG_CHAN_CTL: chan_ctl_d = i_wr_data;
            REG_IRQ_CFG:  aci_d      = i_wr_data[IRQ_ACI_LSB +: 2];
            default: ;
         endcase
      end
      if (i_rd) begin
         case (i_addr)
            REG_CONFIG:   rd_d = config_q;
            REG_CHAN_CTL: rd_d = chan_ctl_q;
            REG_STATE:    rd_d = {4'h0, pressed_q};
            REG_CHANGE:   rd_d = {4'h0, change_q};
            REG_IRQ_CFG:  rd_d = {aci_q, 6'h00};
            default:      rd_d = 8'h00;
         endcase
      end
      // interrupt: event sets and restarts timer; set wins over clear
      if (|ev) begin
         irq_d = 1'b1;
         tmr_d = 32'h0;
      end else if (irq_q) begin
         tmr_d = tmr_q + 32'h1;
         if (chg_access) irq_d = 1'b0;
         else if (aci_q == ACI_SHORT && tmr_q >= P_AUTOCLR_SHORT_CYC - 1) irq_d = 1'b0;
         else if (aci_q == ACI_LONG && tmr_q >= P_AUTOCLR_LONG_CYC - 1) irq_d = 1'b0;
      end else begin
         tmr_d = 32'h0;
      end
      irq_n_d = !irq_d;                                      // pin level kept in its own flop
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         config_q   <= RST_CONFIG;
         chan_ctl_q <= RST_CHAN_CTL;
         aci_q      <= RST_ACI;
         pressed_q  <= 4'h0;
         change_q   <= 4'h0;
         irq_q      <= 1'b0;
         irq_n_q    <= 1'b1;
         tmr_q      <= 32'h0;
         rd_q       <= 8'h00;
         oe_q       <= 4'h0;
         saddr_q    <= 7'h00;
         cap_q      <= 1'b0;
      end else begin
         config_q   <= config_d;
         chan_ctl_q <= chan_ctl_d;
         aci_q      <= aci_d;
         pressed_q  <= pressed_d;
         change_q   <= change_d;
         irq_q      <= irq_d;
         irq_n_q    <= irq_n_d;
         tmr_q      <= tmr_d;
         rd_q       <= rd_d;
         oe_q       <= oe_d;
         saddr_q    <= saddr_d;
         cap_q      <= cap_d;
      end
   end

   // open-drain pins only ever drive low
   assign o_touch_out_low_ch         = 3'h0;
   assign o_touch_out_low_last_ch    = 1'b0;
   assign o_touch_out_low_ch_oe      = oe_q[2:0];
   assign o_touch_out_low_last_ch_oe = oe_q[3];
   assign o_irq_n                    = irq_n_q;
   assign o_rd_data                  = rd_q;
   assign o_slave_addr               = saddr_q;

   // checks
   a_touch_out_follows: assert property (@(posedge i_clk) disable iff (i_reset)
      1'b1 |=> oe_q == $past(pressed_d)) else $error("touch output not tracking pressed state");
   a_irq_on_event: assert property (@(posedge i_clk) disable iff (i_reset)
      (|ev) |=> !o_irq_n) else $error("event did not assert interrupt");
   a_irq_clear_access: assert property (@(posedge i_clk) disable iff (i_reset)
      (chg_access && !(|ev)) |=> o_irq_n) else $error("change access did not clear interrupt");
   a_shutdown_quiet: assert property (@(posedge i_clk) disable iff (i_reset)
      !run |=> (oe_q == 4'h0) && !(|$past(ev))) else $error("activity during shutdown");
   a_disabled_silent: assert property (@(posedge i_clk) disable iff (i_reset)
      ((ev & ~en) == 4'h0) && ((pressed_q & ~$past(en)) == 4'h0))
      else $error("event or press on disabled channel");
   a_addr_fixed: assert property (@(posedge i_clk) disable iff (i_reset)
      cap_q |-> o_slave_addr[6:2] == 5'h11) else $error("slave address upper bits wrong");
   a_chan_write: assert property (@(posedge i_clk) disable iff (i_reset)
      (i_wr && i_addr == REG_CHAN_CTL) |=> en == $past(i_wr_data[3:0])) else $error("enable write lost");
   a_change_sticky: assert property (@(posedge i_clk) disable iff (i_reset)
      (|ev) |=> (change_q & $past(ev)) == $past(ev)) else $error("change flag not set");
   a_autoclr_short: assert property (@(posedge i_clk) disable iff (i_reset)
      (irq_q && aci_q == ACI_SHORT && tmr_q == P_AUTOCLR_SHORT_CYC - 1 && !(|ev)) |=> o_irq_n)
      else $error("short auto clear missed");
   a_no_autoclr: assert property (@(posedge i_clk) disable iff (i_reset)
      (irq_q && aci_q == ACI_NONE && !chg_access) |=> !o_irq_n) else $error("interrupt cleared without access");

endmodule // tce_touch_event
`default_nettype wire

// File: verification/tce_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
module tce_pad_model (
   // driver side of the four open-drain outputs
   input  wire logic [3:0] i_oe,
   input  wire logic [3:0] i_val,
   // resolved pin levels
   output logic      [3:0] o_pin
);
   // pull-up wins wherever the device lets go of the pin
   assign o_pin = (i_val & i_oe) | ~i_oe;
endmodule // tce_pad_model
`default_nettype wire

// File: verification/touch_channel_event_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
module touch_channel_event_logic_tb;
   import tce_pkg::*;
   logic       clk, rst, sd_n, wr, rd, ovl, oel, irq_n;
   logic [3:0] sense, pin;
   logic [1:0] strap;
   logic [2:0] ov, oe;
   logic [6:0] saddr;
   logic [7:0] addr, wdata, rdata;
   logic [7:0] rst_tab [6] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] e2_tab [4] = '{8'h01, 8'h01, 8'h00, 8'h00};
   int         w1_tab [4] = '{20, 150, 150, 150};
   int         n_mismatch = 0;
   int         cmp_count = 0;
   int         cyc = 0;

   tce_touch_event #(.P_AUTOCLR_SHORT_CYC(50), .P_AUTOCLR_LONG_CYC(200), .P_RECAL_CYC(100)) dut (
      .i_clk(clk), .i_reset(rst), .i_sense_in(sense), .i_shutdown_n(sd_n), .i_addr_strap(strap),
      .i_touch_out_low_ch(pin[2:0]), .o_touch_out_low_ch(ov), .o_touch_out_low_ch_oe(oe),
      .i_touch_out_low_last_ch(pin[3]), .o_touch_out_low_last_ch(ovl), .o_touch_out_low_last_ch_oe(oel),
      .o_irq_n(irq_n), .o_slave_addr(saddr), .i_addr(addr), .i_wr_data(wdata), .i_wr(wr), .i_rd(rd),
      .o_rd_data(rdata));

   tce_pad_model pads (.i_oe({oel, oe}), .i_val({ovl, ov}), .o_pin(pin));

   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one-cycle write strobe
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // read strobe, data checked in the following cycle
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask

   task automatic set_sense(input logic [3:0] v, input int n);
      @(posedge clk);
      sense <= v;
      repeat (n) @(posedge clk);
      #1;
   endtask

   // main sequence
   initial begin
      {rst, sd_n, strap, sense, wr, rd, addr, wdata} = {1'b1, 1'b1, 2'h2, 4'h0, 2'h0, 16'h0000};
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      set_sense(4'h0, 3);
      chk({1'b0, saddr}, {1'b0, SLAVE_ADDR_HI, 2'h2});
      chk({7'h00, irq_n}, 8'h01);
      foreach (rst_tab[i]) rd_reg(8'(i), rst_tab[i]);
      // each channel: press, then release
      for (int c = 0; c < 4; c++) begin
         set_sense(4'h1 << c, 25);
         chk({4'h0, ~pin}, 8'h01 << c);
         chk({7'h00, irq_n}, 8'h00);
         rd_reg(REG_STATE, 8'h01 << c);
         rd_reg(REG_CHANGE, 8'h01 << c);
         chk({7'h00, irq_n}, 8'h01);
         set_sense(4'h0, 25);
         chk({4'h0, ~pin}, 8'h00);
         chk({7'h00, irq_n}, 8'h00);
         rd_reg(REG_CHANGE, 8'h01 << c);
         rd_reg(REG_CHANGE, 8'h00);
      end
      // disabled channel stays silent
      wr_reg(REG_CHAN_CTL, 8'hFD);
      rd_reg(REG_CHAN_CTL, 8'hFD);
      set_sense(4'h2, 25);
      chk({4'h0, ~pin}, 8'h00);
      rd_reg(REG_CHANGE, 8'h00);
      set_sense(4'h0, 5);
      wr_reg(REG_CHAN_CTL, 8'hFF);
      // pin shutdown releases without an event; register shutdown blocks a new press
      set_sense(4'h1, 25);
      rd_reg(REG_CHANGE, 8'h01);
      @(posedge clk);
      sd_n <= 1'b0;
      set_sense(4'h0, 10);
      chk({3'h0, irq_n, ~pin}, 8'h10);
      rd_reg(REG_CHANGE, 8'h00);
      @(posedge clk);
      sd_n <= 1'b1;
      wr_reg(REG_CONFIG, 8'hBF);
      rd_reg(REG_CONFIG, 8'hA0);
      set_sense(4'h4, 25);
      chk({3'h0, irq_n, ~pin}, 8'h10);
      set_sense(4'h0, 5);
      wr_reg(REG_CONFIG, 8'h00);
      // sensitivity codes move the press point: high presses early, low late
      wr_reg(REG_CONFIG, 8'h20);
      set_sense(4'h1, 11);
      chk({4'h0, ~pin}, 8'h01);
      set_sense(4'h0, 20);
      wr_reg(REG_CONFIG, 8'h40);
      set_sense(4'h1, 16);
      chk({4'h0, ~pin}, 8'h00);
      set_sense(4'h1, 1);
      chk({4'h0, ~pin}, 8'h01);
      rd_reg(REG_CHANGE, 8'h01);
      set_sense(4'h0, 20);
      rd_reg(REG_CHANGE, 8'h01);
      wr_reg(REG_CONFIG, 8'h00);
      // unmapped and read-only places
      wr_reg(8'h07, 8'hAA);
      rd_reg(8'h07, 8'h00);
      wr_reg(REG_STATE, 8'hFF);
      rd_reg(REG_STATE, 8'h00);
      // auto-clear codes 01, 10, 11, 00
      for (int k = 0; k < 4; k++) begin
         wr_reg(REG_IRQ_CFG, {2'(k + 1), 6'h00});
         set_sense(4'h8, 25);
         set_sense(4'h0, 20);
         chk({7'h00, irq_n}, 8'h00);
         set_sense(4'h0, w1_tab[k]);
         chk({7'h00, irq_n}, 8'h00);
         set_sense(4'h0, 80);
         chk({7'h00, irq_n}, e2_tab[k]);
         rd_reg(REG_CHANGE, 8'h08);
      end
      // long press is absorbed as drift; a write to the change register clears the interrupt
      wr_reg(REG_IRQ_CFG, 8'h00);
      set_sense(4'h4, 30);
      rd_reg(REG_CHANGE, 8'h04);
      set_sense(4'h4, 100);
      chk({3'h0, irq_n, ~pin}, 8'h00);
      wr_reg(REG_CHANGE, 8'h00);
      set_sense(4'h4, 1);
      chk({7'h00, irq_n}, 8'h01);
      rd_reg(REG_CHANGE, 8'h04);
      set_sense(4'h0, 25);
      chk({3'h0, irq_n, ~pin}, 8'h10);
      // second reset with another strap code: address recaptured, channel control back to its default
      wr_reg(REG_CHAN_CTL, 8'h5A);
      @(posedge clk);
      strap <= 2'h1;
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      set_sense(4'h0, 3);
      chk({1'b0, saddr}, {1'b0, SLAVE_ADDR_HI, 2'h1});
      chk({7'h00, irq_n}, 8'h01);
      rd_reg(REG_CHAN_CTL, 8'hFF);
      print_verdict();
   end
endmodule // touch_channel_event_logic_tb
`default_nettype wire
